// File: pac_pkg.sv
/*
 Constants, field positions, reset values and types for the port
 authentication and uplink configuration register bank.
 Assumes a byte-wide management port with byte offsets.
*/
// How it works
// [R1] each port register bit 2 enables access list checking, resets to 0
// [R2] auth mode 00 or 10 passes all traffic, list misses too
// [R3] auth mode 01 blocks all, or only list misses when list enabled
// [R4] auth mode 11 without list redirects all received traffic to processor port
// [R5] auth mode 11 with list redirects only misses, target is port 4
// [R6] uplink bit 6 selects gigabit, clear selects 10/100 in RGMII
// [R7] gigabit bit loaded from speed strap at reset, default gigabit
// [R8] in 10/100 setting, global control bit 4 picks 10 or 100
// [R9] uplink bit 4 adds receive clock delay, resets to 0
// [R10] uplink bit 3 adds transmit clock delay of 1 ns or more, resets 1
// [R11] cleared delay bit means no added delay on that clock
// [R12] uplink bit 2 selects MII role, 1 MAC, 0 PHY, default MAC
// [R13] MII role bit loaded from role strap at reset
// [R14] PHY role drives CRS, COL, RXC, TXC; attached MAC must not
// [R15] port register bits 7 to 3 read-only, read as zero
// [R16] two-bit interface type: 00 MII, 01 RMII, 11 RGMII, strap-loaded
// [R17] setting changes apply only to frames starting after the write
package pac_pkg;
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 8;
   localparam int          NUM_PORTS   = 3;
   localparam logic [7:0]  P1_AUTH_OFS = 8'h15;
   localparam logic [7:0]  P2_AUTH_OFS = 8'h25;
   localparam logic [7:0]  P3_AUTH_OFS = 8'h35;
   localparam logic [7:0]  UPLINK_OFS  = 8'h56;
   localparam logic [7:0]  GLOBAL4_OFS = 8'h06;
   localparam int          ACL_EN_BIT  = 2;
   localparam int          AUTH_LSB    = 0;
   localparam int          GIG_BIT     = 6;
   localparam int          RSV5_BIT    = 5;
   localparam int          RXDLY_BIT   = 4;
   localparam int          TXDLY_BIT   = 3;
   localparam int          ROLE_BIT    = 2;
   localparam int          IFTYPE_LSB  = 0;
   localparam int          SPD100_BIT  = 4;
   localparam logic        ACL_EN_RST  = 1'b0;
   localparam logic        GIG_RST     = 1'b1;
   localparam logic        RSV5_VAL    = 1'b1;
   localparam logic        RXDLY_RST   = 1'b0;
   localparam logic        TXDLY_RST   = 1'b1;
   localparam logic        ROLE_RST    = 1'b1;
   localparam logic        SPD100_RST  = 1'b1;
   localparam logic [2:0]  CPU_PORT    = 3'h4;
   localparam logic [3:0]  MII_OE_ALL  = 4'hF;
   // minimum added transmit clock skew, realised in the pad delay cell
   localparam int          TXDLY_MIN_NS = 1;

   typedef enum logic [1:0] {
      AUTH_OPEN  = 2'b00,
      AUTH_BLOCK = 2'b01,
      AUTH_OPEN2 = 2'b10,
      AUTH_TRAP  = 2'b11
   } pac_auth_t;

   typedef enum logic [1:0] {
      IF_MII   = 2'b00,
      IF_RMII  = 2'b01,
      IF_RSVD  = 2'b10,
      IF_RGMII = 2'b11
   } pac_if_t;

   typedef enum logic {
      ST_STRAP = 1'b0,
      ST_RUN   = 1'b1
   } pac_st_t;

   localparam pac_auth_t   AUTH_RST    = AUTH_OPEN;
   localparam pac_if_t     IFTYPE_RST  = IF_RGMII;
endpackage

// File: pac_top.sv
/*
 Port authentication and uplink interface configuration bank.
 Assumes a management master with one-cycle strobes, straps stable at
 reset release, and frame starts and uplink idle timed to the clock.
*/
`timescale 1ns/1ps
module pac_top
   import pac_pkg::*;
#(
   parameter int NPORT = pac_pkg::NUM_PORTS
)(
   input  wire logic                       clk_sys_i,
   input  wire logic                       rstn_i,
   input  wire logic [pac_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [pac_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [pac_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                       speed_strap_pin_i,
   input  wire logic                       mii_role_strap_pin_i,
   input  wire logic [1:0]                 interface_type_strap_pins_i,
   input  wire logic [NPORT-1:0]           frame_start_i,
   input  wire logic [NPORT-1:0]           acl_miss_i,
   output logic      [NPORT-1:0]           dec_valid_o,
   output logic      [NPORT-1:0]           dec_pass_o,
   output logic      [NPORT-1:0]           dec_block_o,
   output logic      [NPORT-1:0]           dec_redirect_o,
   output logic      [2:0]                 redirect_port_o,
   input  wire logic                       uplink_idle_i,
   output logic                            gigabit_speed_select_o,
   output logic                            speed_100_o,
   output logic                            rx_clk_delay_en_o,
   output logic                            tx_clk_delay_en_o,
   output logic                            mii_mac_role_o,
   output logic      [1:0]                 interface_type_o,
   output logic      [3:0]                 mii_pin_oe_o
);
   import pac_pkg::*;

   logic      [NPORT-1:0] acl_en_q;
   pac_auth_t             auth_q [NPORT];
   pac_st_t               st_q;
   logic                  gig_q;
   logic                  rxdly_q;
   logic                  txdly_q;
   logic                  role_q;
   pac_if_t               iftype_q;
   logic                  spd100_q;
   logic                  wr_up;

   function automatic logic [7:0] auth_ofs(input int idx);
      unique case (idx)
         0:       auth_ofs = P1_AUTH_OFS;
         1:       auth_ofs = P2_AUTH_OFS;
         default: auth_ofs = P3_AUTH_OFS;
      endcase
   endfunction

   // returns {redirect, block, pass}
   function automatic logic [2:0] decide(input pac_auth_t mode,
                                         input logic acl_en,
                                         input logic miss);
      logic hit;
      hit = acl_en & ~miss;
      unique case (mode)
         // [R3] block or miss-only
         AUTH_BLOCK: decide = hit ? 3'h1 : 3'h2;
         // [R4] [R5] redirect to processor
         AUTH_TRAP:  decide = hit ? 3'h1 : 3'h4;
         // [R2] forced authorized
         AUTH_OPEN,
         AUTH_OPEN2: decide = 3'h1;
      endcase
   endfunction

   // port settings
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         acl_en_q <= '0;
         for (int i = 0; i < NPORT; i++)
         begin
            auth_q[i] <= AUTH_RST;
         end
      end
      else if (wr_i)
      begin
         for (int i = 0; i < NPORT; i++)
         begin
            if (addr_i == auth_ofs(i))
            begin
               // [R1] list enable bit
               acl_en_q[i] <= wdata_i[ACL_EN_BIT];
               auth_q[i]   <= pac_auth_t'(wdata_i[AUTH_LSB +: 2]);
            end
         end
      end
   end

   // straps are caught on the first edge after release, not by the reset
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_q <= ST_STRAP;
      end
      else
      begin
         st_q <= ST_RUN;
      end
   end

   assign wr_up = wr_i && (addr_i == UPLINK_OFS) && (st_q == ST_RUN);

   // uplink settings
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         gig_q    <= GIG_RST;
         rxdly_q  <= RXDLY_RST;
         txdly_q  <= TXDLY_RST;
         role_q   <= ROLE_RST;
         iftype_q <= IFTYPE_RST;
      end
      else if (st_q == ST_STRAP)
      begin
         // [R7] speed strap
         gig_q    <= speed_strap_pin_i;
         // [R13] role strap
         role_q   <= mii_role_strap_pin_i;
         // [R16] type strap
         iftype_q <= pac_if_t'(interface_type_strap_pins_i);
      end
      else if (wr_up)
      begin
         // [R6] gigabit select
         gig_q   <= wdata_i[GIG_BIT];
         // [R9] receive delay
         rxdly_q <= wdata_i[RXDLY_BIT];
         // [R10] transmit delay
         txdly_q <= wdata_i[TXDLY_BIT];
         // [R12] MII role
         role_q  <= wdata_i[ROLE_BIT];
         // [R16] reserved code ignored
         if (wdata_i[IFTYPE_LSB +: 2] != IF_RSVD)
         begin
            iftype_q <= pac_if_t'(wdata_i[IFTYPE_LSB +: 2]);
         end
      end
   end

   // global 10 or 100 choice
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         spd100_q <= SPD100_RST;
      end
      else if (wr_i && addr_i == GLOBAL4_OFS)
      begin
         spd100_q <= wdata_i[SPD100_BIT];
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_o <= 8'h00;
      end
      else
      begin
         rdata_o <= 8'h00;
         if (rd_i)
         begin
            for (int i = 0; i < NPORT; i++)
            begin
               if (addr_i == auth_ofs(i))
               begin
                  // [R15] upper bits read zero
                  rdata_o <= {5'h00, acl_en_q[i], auth_q[i]};
               end
            end
            if (addr_i == UPLINK_OFS)
            begin
               rdata_o <= {1'b0, gig_q, RSV5_VAL, rxdly_q, txdly_q,
                           role_q, iftype_q};
            end
            if (addr_i == GLOBAL4_OFS)
            begin
               rdata_o <= {3'h0, spd100_q, 4'h0};
            end
         end
      end
   end

   // per-frame decisions; settings are sampled at frame start so a
   // write never splits a frame
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dec_valid_o     <= '0;
         dec_pass_o      <= '0;
         dec_block_o     <= '0;
         dec_redirect_o  <= '0;
         redirect_port_o <= 3'h0;
      end
      else
      begin
         // [R5] processor port number
         redirect_port_o <= CPU_PORT;
         dec_valid_o     <= frame_start_i;
         for (int i = 0; i < NPORT; i++)
         begin
            // [R17] sample at frame start
            if (frame_start_i[i])
            begin
               {dec_redirect_o[i], dec_block_o[i], dec_pass_o[i]} <=
                  decide(auth_q[i], acl_en_q[i], acl_miss_i[i]);
            end
         end
      end
   end

   // uplink settings reach the interface only between frames
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         gigabit_speed_select_o <= GIG_RST;
         speed_100_o            <= SPD100_RST;
         rx_clk_delay_en_o      <= RXDLY_RST;
         tx_clk_delay_en_o      <= TXDLY_RST;
         mii_mac_role_o         <= ROLE_RST;
         interface_type_o       <= IFTYPE_RST;
         mii_pin_oe_o           <= 4'h0;
      end
      // [R17] apply when idle
      else if (uplink_idle_i && st_q == ST_RUN)
      begin
         gigabit_speed_select_o <= gig_q;
         // [R8] global 10 or 100
         speed_100_o            <= spd100_q;
         // [R11] cleared bit, no delay
         rx_clk_delay_en_o      <= rxdly_q;
         tx_clk_delay_en_o      <= txdly_q;
         mii_mac_role_o         <= role_q;
         interface_type_o       <= iftype_q;
         // [R14] PHY role drives pins, in MII interface type only
         mii_pin_oe_o           <= (iftype_q == IF_MII && !role_q) ?
                                   MII_OE_ALL : 4'h0;
      end
   end
endmodule // pac_top

// File: pac_checker.sv
/* timing relations of frame decisions, read port and uplink outputs;
   bound into pac_top and sees only its ports */
`timescale 1ns/1ps
module pac_checker
   import pac_pkg::*;
#(
   parameter int NPORT = 3
)(
   input wire logic             clk_sys_i,
   input wire logic             rstn_i,
   input wire logic             rd_i,
   input wire logic [7:0]       rdata_o,
   input wire logic [NPORT-1:0] frame_start_i,
   input wire logic [NPORT-1:0] dec_valid_o,
   input wire logic [NPORT-1:0] dec_pass_o,
   input wire logic [NPORT-1:0] dec_block_o,
   input wire logic [NPORT-1:0] dec_redirect_o,
   input wire logic [2:0]       redirect_port_o,
   input wire logic             uplink_idle_i,
   input wire logic             mii_mac_role_o,
   input wire logic [1:0]       interface_type_o,
   input wire logic [3:0]       mii_pin_oe_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   valid_pulse_a:
      assert property (frame_start_i != '0 |=> dec_valid_o == $past(frame_start_i)) else $error("no decision");
   valid_cause_a:
      assert property (dec_valid_o[0] |-> $past(frame_start_i[0])) else $error("decision without frame");
   dec_onehot_a:
      assert property (dec_valid_o[0] |-> $onehot({dec_pass_o[0], dec_block_o[0], dec_redirect_o[0]}))
      else $error("decision not one-hot");
   dec_hold_a:
      assert property (!$past(frame_start_i[0]) |-> $stable({dec_pass_o[0], dec_block_o[0], dec_redirect_o[0]}))
      else $error("decision changed mid frame");
   redir_port_a:
      assert property ($past(rstn_i) |-> redirect_port_o == CPU_PORT) else $error("wrong redirect port");
   rdata_idle_a:
      assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside read slot");
   uplink_hold_a:
      assert property (!$past(uplink_idle_i) |-> $stable({mii_mac_role_o, interface_type_o, mii_pin_oe_o}))
      else $error("uplink changed while busy");
   pin_oe_a:
      assert property (mii_pin_oe_o == ((!mii_mac_role_o && interface_type_o == IF_MII) ? MII_OE_ALL : 4'h0))
      else $error("pin enables wrong for role");
endmodule // pac_checker

bind pac_top pac_checker #(.NPORT(NPORT)) u_chk (.*);

// File: pac_link_model.sv
/* host on the uplink: frames with idle gaps, lets go of the shared pins;
   assumes the bench clock and reset */
`timescale 1ns/1ps
module pac_link_model (
   input  wire logic       clk_sys_i,
   input  wire logic       rstn_i,
   input  wire logic       slow_i,
   input  wire logic [3:0] mii_pin_oe_i,
   output logic            uplink_idle_o,
   output logic [3:0]      mac_pin_oe_o
);
   logic [2:0] cnt_q;
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_q <= 3'h0;
      else
         cnt_q <= cnt_q + 3'h1;
   end
   // slow host leaves one idle cycle in eight, so updates must wait for it
   assign uplink_idle_o = !slow_i || (cnt_q == 3'h7);
   assign mac_pin_oe_o = ~mii_pin_oe_i;
endmodule // pac_link_model

// File: tb_port_auth_and_uplink_config.sv
/* self-checking bench of the register bank and frame decisions;
   drives the management port and frame starts, the model drives idle */
`timescale 1ns/1ps
module tb_port_auth_and_uplink_config;
   import pac_pkg::*;
   logic        clk_sys_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, slow = 0, rd_q = 0;
   logic [7:0]  addr_i = 0, wdata_i = 0, rdata_o;
   logic [2:0]  fs = 0, ms = 0, dv, dp, db, dr, rp;
   logic        idle, gig, s100, rxd, txd, role, sp = 0, rl = 0;
   logic [1:0]  ift, it = 0;
   logic [3:0]  oe, hoe;
   logic [31:0] seed = 32'h14;
   logic [7:0]  rq[$];
   logic [2:0]  dq[$];
   int          failures = 0, num_checks = 0;

   always #20 clk_sys_i = ~clk_sys_i;

   pac_top i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .speed_strap_pin_i(sp), .mii_role_strap_pin_i(rl),
      .interface_type_strap_pins_i(it), .frame_start_i(fs), .acl_miss_i(ms), .dec_valid_o(dv),
      .dec_pass_o(dp), .dec_block_o(db), .dec_redirect_o(dr), .redirect_port_o(rp), .uplink_idle_i(idle),
      .gigabit_speed_select_o(gig), .speed_100_o(s100), .rx_clk_delay_en_o(rxd), .tx_clk_delay_en_o(txd),
      .mii_mac_role_o(role), .interface_type_o(ift), .mii_pin_oe_o(oe));
   pac_link_model i_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .slow_i(slow), .mii_pin_oe_i(oe),
      .uplink_idle_o(idle), .mac_pin_oe_o(hoe));

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   // {pass, block, redirect}; a list hit always passes
   function automatic logic [2:0] dec(logic [2:0] r, logic m);
      if (!r[0] || (r[2] && !m))
         return 3'h4;
      return r[1] ? 3'h1 : 3'h2;
   endfunction

   task automatic cmp(string n, logic [7:0] x, logic [7:0] s);
      num_checks++;
      if (s !== x)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic cmp_rd(logic [7:0] x, logic [7:0] s);
      cmp("rdata", x, s);
   endtask

   task automatic cmp_dec(string n, logic [7:0] x, logic [7:0] s);
      cmp(n, x, s);
   endtask

   task automatic cmp_up(string n, logic [7:0] x, logic [7:0] s);
      cmp(n, x, s);
   endtask

   task automatic drv(logic w, logic r, logic [7:0] a, logic [7:0] d, logic [2:0] f, logic [2:0] m);
      @(posedge clk_sys_i);
      {wr_i, rd_i, addr_i, wdata_i, fs, ms} <= {w, r, a, d, f, m};
      @(posedge clk_sys_i);
      {wr_i, rd_i, fs} <= 5'h00;
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] x);
      rq.push_back(x);
      drv(0, 1, a, 8'h00, 3'h0, 3'h0);
   endtask

   task automatic report_and_stop();
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk_sys_i)
      rd_q <= rd_i;

   always @(negedge clk_sys_i)
   begin
      if (rd_q)
         cmp_rd(rq.pop_front(), rdata_o);
      for (int i = 0; i < 3; i++)
         if (dv[i] === 1'b1)
         begin
            cmp_dec("decision", {5'h00, dq.pop_front()}, {5'h00, dp[i], db[i], dr[i]});
            if (dr[i] === 1'b1)
               cmp_dec("redirect port", 8'h04, {5'h00, rp});
         end
   end

   initial
   begin
      logic [7:0] d;
      logic [7:0] u;
      logic [2:0] r[3];
      r = '{default: 3'h0};
      repeat (3) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rd(UPLINK_OFS, 8'h28);
      rd(GLOBAL4_OFS, 8'h10);
      @(negedge clk_sys_i);
      cmp_up("uplink", {2'h0, gig, rxd, txd, role, ift}, 8'h08);
      cmp_up("pin oe", {4'h0, oe}, 8'h0F);
      for (int k = 0; k < 48; k++)
      begin
         logic [1:0] p;
         logic       m;
         p = 2'(k % 3);
         m = k[5];
         d = {rnd() & 8'hF8} | 8'(k / 3) & 8'h07;
         // write and frame on one edge: the frame must see the old setting
         dq.push_back(dec(r[p], m));
         drv(1, 0, 8'h15 + 8'(p * 16), d, 3'h1 << p, {3{m}});
         r[p] = d[2:0];
         dq.push_back(dec(r[p], m));
         drv(0, 0, 8'h00, 8'h00, 3'h1 << p, {3{m}});
         rd(8'h15 + 8'(p * 16), {5'h00, d[2:0]});
      end
      slow <= 1'b1;
      u = 8'h28;
      for (int k = 0; k < 8; k++)
      begin
         d = rnd();
         if (k == 1)
            d[1:0] = 2'h2;
         u = {1'b0, d[6], 1'b1, d[4:2], (d[1:0] == 2'h2) ? u[1:0] : d[1:0]};
         drv(1, 0, UPLINK_OFS, d, 3'h0, 3'h0);
         drv(1, 0, GLOBAL4_OFS, d, 3'h0, 3'h0);
         rd(UPLINK_OFS, u);
         rd(GLOBAL4_OFS, d & 8'h10);
         repeat (10) @(negedge clk_sys_i);
         cmp_up("uplink", {1'b0, gig, s100, rxd, txd, role, ift}, {1'b0, u[6], d[4], u[4:0]});
         cmp_up("pin oe", {4'h0, oe}, (u[2:0] == 3'h0) ? 8'h0F : 8'h00);
         cmp_up("pin clash", 8'h00, {4'h0, oe & hoe});
      end
      // second reset in mid-run with all straps pulled up: gigabit, MAC, RGMII
      @(posedge clk_sys_i);
      {rstn_i, sp, rl, it} <= 5'h0F;
      repeat (3) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rd(UPLINK_OFS, 8'h6F);
      rd(8'h25, 8'h00);
      repeat (10) @(negedge clk_sys_i);
      cmp_up("uplink", {1'b0, gig, s100, rxd, txd, role, ift}, 8'h6F);
      cmp_up("pin oe", {4'h0, oe}, 8'h00);
      drv(1, 0, 8'h16, 8'hFF, 3'h0, 3'h0);
      rd(8'h16, 8'h00);
      rd(8'h57, 8'h00);
      // let the read compare of the last strobe run before counting leftovers
      repeat (2) @(negedge clk_sys_i);
      cmp("leftover", 8'h00, 8'(rq.size() + dq.size()));
      report_and_stop();
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys_i);
      failures++;
      report_and_stop();
   end
endmodule // tb_port_auth_and_uplink_config
